// ===== design/bat_accum.sv
// One 32-bit wrapping accumulator or elapsed counter
`timescale 1ns/1ps
module bat_accum
    import bat_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic clr,
    input wire logic add,
    input wire logic [31:0] addVal,
    // Value
    output logic [31:0] value
);

    typedef struct packed {
        logic [31:0] value;
    } bat_accum_state_t;

    bat_accum_state_t s_q;
    bat_accum_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (clr)
            s_d.value = '0;
        else if (add)
            s_d.value = s_q.value + addVal;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign value = s_q.value;

endmodule : bat_accum

// ===== design/bat_accum_timers.sv
// Battery monitor accumulators, elapsed counters and conversion scheduler
`timescale 1ns/1ps
module bat_accum_timers
    import bat_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // Conversion results
    input wire logic currentDone,
    input wire logic [15:0] currentResult,
    input wire logic intTempDone,
    input wire logic [15:0] intTempResult,
    input wire logic extTempDone,
    input wire logic [15:0] externalTempResult,
    input wire logic cell2Done,
    input wire logic [15:0] cell2Result,
    input wire logic cell2Active,
    // Power state
    input wire logic lowPowerHold,
    // Conversion scheduling
    output logic convStart,
    output logic convContinuous
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] wordByte(
        input logic [31:0] w,
        input logic [1:0] idx
    );
        logic [31:0] sh;
        sh = w >> {idx, 3'b000};
        return sh[7:0];
    endfunction : wordByte

    function automatic logic [7:0] periodLast(
        input logic [SETUP_EXP_W-1:0] exponent
    );
        logic [8:0] p;
        p = 9'h001 << exponent;
        return 8'(p - 9'h001);
    endfunction : periodLast

    function automatic logic sameWord(
        input logic [7:0] a,
        input logic [7:0] base
    );
        return a[7:2] == base[7:2];
    endfunction : sameWord

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] accCtrl;
        logic currPos;
        logic [7:0] sampCnt;
        logic convStart;
        logic convRun;
        logic [7:0] rdData;
    } bat_top_state_t;

    bat_top_state_t s_q;
    bat_top_state_t s_d;

    logic tick;
    logic [7:0] clrVec;
    logic master;
    logic convEn;
    logic periodicOn;
    logic [SETUP_EXP_W-1:0] exponent;
    logic chargeInc;
    logic tempDone;
    logic [15:0] tempRes;
    logic tempAdd;
    logic tempTimeInc;
    logic cell2Add;
    logic cell2TimeInc;
    logic [31:0] chargeTime;
    logic [31:0] tempSum;
    logic [31:0] tempElapsed;
    logic [31:0] cell2Sum;
    logic [31:0] cell2Elapsed;

    // ------------------------------------------------------------
    // Tick source
    // ------------------------------------------------------------
    bat_tick_gen #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Enables
    // ------------------------------------------------------------
    always_comb
    begin
        clrVec = (regWrEn && regAddr == ADDR_SUM_CLEAR) ? regWrData : 8'h00;
        master = s_q.accCtrl[CTRL_MASTER_BIT];
        convEn = s_q.setup[SETUP_EN_BIT];
        periodicOn = convEn && s_q.setup[SETUP_PERIODIC_BIT] && !lowPowerHold;
        exponent = s_q.setup[SETUP_EXP_LSB +: SETUP_EXP_W];
        chargeInc = tick && master && s_q.accCtrl[CTRL_CURRENT_BIT]
            && s_q.currPos;
        tempDone = s_q.accCtrl[CTRL_TSEL_BIT] ? extTempDone : intTempDone;
        tempRes = s_q.accCtrl[CTRL_TSEL_BIT] ? externalTempResult
            : intTempResult;
        tempAdd = tempDone && master && s_q.accCtrl[CTRL_TEMP_BIT];
        tempTimeInc = tick && master && s_q.accCtrl[CTRL_TEMP_BIT];
        cell2Add = cell2Done && master && s_q.accCtrl[CTRL_CELL2_BIT];
        cell2TimeInc = tick && master && s_q.accCtrl[CTRL_CELL2_BIT]
            && cell2Active;
    end

    // ------------------------------------------------------------
    // Counters and accumulators
    // ------------------------------------------------------------
    bat_accum u_charge_time (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .clr(clrVec[CLR_CHARGE_TIME_BIT]),
        .add(chargeInc),
        .addVal(32'h0000_0001),
        .value(chargeTime)
    );

    bat_accum u_temp_sum (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .clr(clrVec[CLR_TEMP_SUM_BIT]),
        .add(tempAdd),
        .addVal({16'h0000, tempRes}),
        .value(tempSum)
    );

    bat_accum u_temp_elapsed (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .clr(clrVec[CLR_TEMP_ELAPSED_BIT]),
        .add(tempTimeInc),
        .addVal(32'h0000_0001),
        .value(tempElapsed)
    );

    bat_accum u_cell2_sum (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .clr(clrVec[CLR_CELL2_SUM_BIT]),
        .add(cell2Add),
        .addVal({16'h0000, cell2Result}),
        .value(cell2Sum)
    );

    bat_accum u_cell2_elapsed (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .clr(clrVec[CLR_CELL2_ELAPSED_BIT]),
        .add(cell2TimeInc),
        .addVal(32'h0000_0001),
        .value(cell2Elapsed)
    );

    // ------------------------------------------------------------
    // Registers, scheduler and read path
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.convStart = 1'b0;
        if (regWrEn && regAddr == ADDR_CONV_SETUP)
            s_d.setup = regWrData & SETUP_MASK;
        if (regWrEn && regAddr == ADDR_SUM_CTRL)
            s_d.accCtrl = regWrData & CTRL_MASK;
        if (currentDone)
            s_d.currPos = !currentResult[RESULT_SIGN_BIT];
        if (!periodicOn)
        begin
            s_d.sampCnt = 8'h00;
        end
        else if (tick)
        begin
            if (s_q.sampCnt >= periodLast(exponent))
            begin
                s_d.sampCnt = 8'h00;
                s_d.convStart = 1'b1;
            end
            else
            begin
                s_d.sampCnt = s_q.sampCnt + 8'h01;
            end
        end
        s_d.convRun = convEn && !s_q.setup[SETUP_PERIODIC_BIT]
            && !lowPowerHold;
        if (regRdEn)
        begin
            if (regAddr == ADDR_CONV_SETUP)
                s_d.rdData = s_q.setup;
            else if (regAddr == ADDR_SUM_CTRL)
                s_d.rdData = s_q.accCtrl;
            else if (sameWord(regAddr, ADDR_CHARGE_TIME))
                s_d.rdData = wordByte(chargeTime, regAddr[1:0]);
            else if (sameWord(regAddr, ADDR_TEMP_SUM))
                s_d.rdData = wordByte(tempSum, regAddr[1:0]);
            else if (sameWord(regAddr, ADDR_TEMP_ELAPSED))
                s_d.rdData = wordByte(tempElapsed, regAddr[1:0]);
            else if (sameWord(regAddr, ADDR_CELL2_SUM))
                s_d.rdData = wordByte(cell2Sum, regAddr[1:0]);
            else if (sameWord(regAddr, ADDR_CELL2_ELAPSED))
                s_d.rdData = wordByte(cell2Elapsed, regAddr[1:0]);
            else
                s_d.rdData = 8'h00;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.setup <= SETUP_RESET;
            s_q.accCtrl <= CTRL_RESET;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign regRdData = s_q.rdData;
    assign convStart = s_q.convStart;
    assign convContinuous = s_q.convRun;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence sampEnd;
        ce && tick && periodicOn && s_q.sampCnt >= periodLast(exponent);
    endsequence

    sequence sampMid;
        ce && tick && periodicOn && s_q.sampCnt < periodLast(exponent);
    endsequence

    charge_count_a: assert property (
        ce && chargeInc && !clrVec[CLR_CHARGE_TIME_BIT]
        |=> chargeTime == $past(chargeTime) + 32'h0000_0001
    ) else $error("charge time did not count");

    charge_clear_a: assert property (
        ce && clrVec[CLR_CHARGE_TIME_BIT] |=> chargeTime == 32'h0000_0000
    ) else $error("charge time not cleared");

    charge_wrap_a: assert property (
        ce && chargeInc && !clrVec[CLR_CHARGE_TIME_BIT]
        && chargeTime == 32'hFFFF_FFFF |=> chargeTime == 32'h0000_0000
    ) else $error("charge time did not wrap");

    temp_add_a: assert property (
        ce && tempAdd && !clrVec[CLR_TEMP_SUM_BIT]
        |=> tempSum == $past(tempSum) + {16'h0000, $past(tempRes)}
    ) else $error("temperature sum did not add result");

    temp_clear_a: assert property (
        ce && clrVec[CLR_TEMP_SUM_BIT] |=> tempSum == 32'h0000_0000
    ) else $error("temperature sum not cleared");

    temp_time_a: assert property (
        ce && tempTimeInc && !clrVec[CLR_TEMP_ELAPSED_BIT]
        |=> tempElapsed == $past(tempElapsed) + 32'h0000_0001
    ) else $error("temperature elapsed did not count");

    temp_time_clear_a: assert property (
        ce && clrVec[CLR_TEMP_ELAPSED_BIT] |=> tempElapsed == 32'h0000_0000
    ) else $error("temperature elapsed not cleared");

    cell2_add_a: assert property (
        ce && cell2Add && !clrVec[CLR_CELL2_SUM_BIT]
        |=> cell2Sum == $past(cell2Sum) + {16'h0000, $past(cell2Result)}
    ) else $error("cell-2 sum did not add result");

    cell2_clear_a: assert property (
        ce && clrVec[CLR_CELL2_SUM_BIT] |=> cell2Sum == 32'h0000_0000
    ) else $error("cell-2 sum not cleared");

    cell2_time_a: assert property (
        ce && cell2TimeInc && !clrVec[CLR_CELL2_ELAPSED_BIT]
        |=> cell2Elapsed == $past(cell2Elapsed) + 32'h0000_0001
    ) else $error("cell-2 elapsed did not count");

    cell2_time_clear_a: assert property (
        ce && clrVec[CLR_CELL2_ELAPSED_BIT] |=> cell2Elapsed == 32'h0000_0000
    ) else $error("cell-2 elapsed not cleared");

    conv_off_a: assert property (
        ce && !convEn |=> !convStart && !convContinuous
    ) else $error("conversion requested while disabled");

    run_mode_a: assert property (
        ce && convEn && !s_q.setup[SETUP_PERIODIC_BIT] && !lowPowerHold
        |=> convContinuous && !convStart
    ) else $error("run mode not continuous");

    period_end_a: assert property (
        sampEnd |=> convStart ##1 !convStart || !ce
    ) else $error("periodic start missing at end of period");

    period_mid_a: assert property (
        sampMid |=> !convStart && s_q.sampCnt == $past(s_q.sampCnt) + 8'h01
    ) else $error("periodic start too early");

    master_off_a: assert property (
        ce && !master && clrVec == 8'h00
        |=> $stable(chargeTime) && $stable(tempSum) && $stable(tempElapsed)
        && $stable(cell2Sum) && $stable(cell2Elapsed)
    ) else $error("counting while summing master off");

endmodule : bat_accum_timers

// ===== design/bat_pkg.sv
// Shared constants of the battery accumulator and timer block
package bat_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CHARGE_TIME = 8'h2C;
    localparam logic [7:0] ADDR_TEMP_SUM = 8'h30;
    localparam logic [7:0] ADDR_TEMP_ELAPSED = 8'h34;
    localparam logic [7:0] ADDR_CELL2_SUM = 8'h38;
    localparam logic [7:0] ADDR_CELL2_ELAPSED = 8'h3C;
    localparam logic [7:0] ADDR_CONV_SETUP = 8'h43;
    localparam logic [7:0] ADDR_SUM_CLEAR = 8'h62;
    localparam logic [7:0] ADDR_SUM_CTRL = 8'h63;

    // ------------------------------------------------------------
    // Converter setup fields
    // ------------------------------------------------------------
    localparam int SETUP_EN_BIT = 7;
    localparam int SETUP_PERIODIC_BIT = 6;
    localparam int SETUP_EXP_LSB = 0;
    localparam int SETUP_EXP_W = 3;
    localparam logic [7:0] SETUP_MASK = 8'hC7;
    localparam logic [7:0] SETUP_RESET = 8'h00;

    // ------------------------------------------------------------
    // Summing control and clear fields
    // ------------------------------------------------------------
    localparam int CTRL_MASTER_BIT = 7;
    localparam int CTRL_CURRENT_BIT = 6;
    localparam int CTRL_TEMP_BIT = 5;
    localparam int CTRL_CELL2_BIT = 4;
    localparam int CTRL_TSEL_BIT = 3;
    localparam logic [7:0] CTRL_MASK = 8'hF8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CLR_CHARGE_TIME_BIT = 3;
    localparam int CLR_TEMP_SUM_BIT = 4;
    localparam int CLR_TEMP_ELAPSED_BIT = 5;
    localparam int CLR_CELL2_SUM_BIT = 6;
    localparam int CLR_CELL2_ELAPSED_BIT = 7;
    localparam int RESULT_SIGN_BIT = 15;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned TICK_PERIOD_MS = 500;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

endpackage : bat_pkg

// ===== design/bat_tick_gen.sv
// Half-second tick strobe generator
`timescale 1ns/1ps
module bat_tick_gen
    import bat_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Strobe
    output logic tick
);

    typedef struct packed {
        logic [24:0] cnt;
        logic tick;
    } bat_tick_state_t;

    bat_tick_state_t s_q;
    bat_tick_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= 25'(TICK_CYCLES_P - 1))
        begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 25'h000_0001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign tick = s_q.tick;

    tick_single_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (tick && ce) |=> !tick
    ) else $error("tick strobe lasted more than one cycle");

endmodule : bat_tick_gen

// ===== verification/bat_host_model.sv
// Host-side register access model for the accumulator block
`timescale 1ns/1ps
module bat_host_model
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    initial
    begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end

    // ------------------------------------------------------------
    // Byte accesses
    // ------------------------------------------------------------
    // Write held until its sampling edge, data scrambled afterwards
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask : wr

    // Read strobe for one edge, byte taken once it has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd

    // Counter read, lowest byte first
    task automatic rd32(input logic [7:0] base, output logic [31:0] v);
        logic [7:0] b;
        for (int i = 0; i < 4; i++)
        begin
            rd(base + 8'(i), b);
            v[8*i +: 8] = b;
        end
    endtask : rd32

    // Host maintenance: clear counters before they overflow
    task automatic clr(input logic [7:0] m);
        wr(8'h62, m);
    endtask : clr
endmodule : bat_host_model

// ===== verification/testbench.sv
// Self-checking testbench of the accumulator and timer block
`timescale 1ns/1ps
module testbench;
    import bat_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] regAddr, regWrData, regRdData;
    logic regWrEn, regRdEn;
    logic currentDone = 1'b0, intTempDone = 1'b0;
    logic extTempDone = 1'b0, cell2Done = 1'b0;
    logic [15:0] currentResult = 16'h0000, intTempResult = 16'h0000;
    logic [15:0] externalTempResult = 16'h0000, cell2Result = 16'h0000;
    logic cell2Active = 1'b0, lowPowerHold = 1'b0;
    logic convStart, convContinuous;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] v;
    logic [7:0] b;
    int n;

    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    bat_accum_timers #(.TICK_CYCLES_P(8)) DUT
    (
        .ref_clk(ref_clk), .rst(rst), .ce(ce),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData),
        .currentDone(currentDone), .currentResult(currentResult),
        .intTempDone(intTempDone), .intTempResult(intTempResult),
        .extTempDone(extTempDone), .externalTempResult(externalTempResult),
        .cell2Done(cell2Done), .cell2Result(cell2Result),
        .cell2Active(cell2Active), .lowPowerHold(lowPowerHold),
        .convStart(convStart), .convContinuous(convContinuous)
    );

    bat_host_model host
    (
        .ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One result pulse; external source gets a distinct value
    task automatic res(input logic [3:0] m, input logic [15:0] r);
        @(posedge ref_clk);
        {cell2Done, extTempDone, intTempDone, currentDone} <= m;
        {currentResult, intTempResult, cell2Result} <= {3{r}};
        externalTempResult <= r ^ 16'h0F00;
        @(posedge ref_clk);
        {cell2Done, extTempDone, intTempDone, currentDone} <= 4'h0;
        {currentResult, intTempResult, cell2Result} <= {3{~r}};
        externalTempResult <= ~r;
    endtask : res

    // Cycles until the next start pulse, bounded; a needed one that
    // never comes ends the run
    task automatic wait_start(input int lim, input bit need, output int c);
        c = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        while (convStart !== 1'b1 && c < lim);
        if (need && convStart !== 1'b1)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, convStart, 1'b1);
            final_report();
        end
    endtask : wait_start

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        host.rd(ADDR_CONV_SETUP, b);
        chk(b, 8'h00);
        host.rd32(ADDR_CHARGE_TIME, v);
        chk(v, 32'h0000_0000);
        host.rd(8'h70, b);
        chk(b, 8'h00);
        host.wr(ADDR_CONV_SETUP, 8'hFF);
        host.rd(ADDR_CONV_SETUP, b);
        chk(b, 8'hC7);
        host.wr(ADDR_CONV_SETUP, 8'h00);
        host.wr(ADDR_CHARGE_TIME, 8'hFF);
        host.rd(ADDR_CHARGE_TIME, b);
        chk(b, 8'h00);
        host.rd(ADDR_SUM_CLEAR, b);
        chk(b, 8'h00);
        $display("test regs done");
    endtask : test_regs

    task automatic test_temp_sum;
        host.wr(ADDR_SUM_CTRL, 8'hA0);
        res(4'b0110, 16'h0005);
        host.wr(ADDR_SUM_CTRL, 8'hA8);
        res(4'b0110, 16'h0009);
        host.wr(ADDR_SUM_CTRL, 8'h28);
        res(4'b0110, 16'h0003);
        host.rd32(ADDR_TEMP_SUM, v);
        chk(v, 32'h0000_0F0E);
        host.clr(8'h10);
        host.rd32(ADDR_TEMP_SUM, v);
        chk(v, 32'h0000_0000);
        $display("test temp sum done");
    endtask : test_temp_sum

    task automatic test_cell2_sum;
        host.wr(ADDR_SUM_CTRL, 8'h90);
        res(4'b1000, 16'h1234);
        res(4'b1000, 16'h1234);
        host.wr(ADDR_SUM_CTRL, 8'h80);
        res(4'b1000, 16'h1111);
        host.rd32(ADDR_CELL2_SUM, v);
        chk(v, 32'h0000_2468);
        host.clr(8'h40);
        host.rd32(ADDR_CELL2_SUM, v);
        chk(v, 32'h0000_0000);
        $display("test cell2 sum done");
    endtask : test_cell2_sum

    // Enable window of exactly 80 edges: ten ticks
    task automatic window(input logic [7:0] c);
        host.wr(ADDR_SUM_CTRL, c);
        repeat (78) @(posedge ref_clk);
        host.wr(ADDR_SUM_CTRL, 8'h00);
    endtask : window

    task automatic elapsed_chk(input logic [31:0] c, t, e);
        host.rd32(ADDR_CHARGE_TIME, v);
        chk(v, c);
        host.rd32(ADDR_TEMP_ELAPSED, v);
        chk(v, t);
        host.rd32(ADDR_CELL2_ELAPSED, v);
        chk(v, e);
    endtask : elapsed_chk

    task automatic test_elapsed;
        host.wr(ADDR_SUM_CTRL, 8'h00);
        host.clr(8'hF8);
        res(4'b0001, 16'h0123);
        cell2Active <= 1'b1;
        window(8'hF0);
        elapsed_chk(32'h0000_000A, 32'h0000_000A, 32'h0000_000A);
        res(4'b0001, 16'h8001);
        cell2Active <= 1'b0;
        window(8'hF0);
        elapsed_chk(32'h0000_000A, 32'h0000_0014, 32'h0000_000A);
        cell2Active <= 1'b1;
        window(8'h70);
        elapsed_chk(32'h0000_000A, 32'h0000_0014, 32'h0000_000A);
        host.clr(8'hF8);
        elapsed_chk(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        $display("test elapsed done");
    endtask : test_elapsed

    // Clock enable low for 50 edges inside a 130-edge window of 80 live edges
    task automatic test_freeze;
        host.clr(8'hF8);
        host.wr(ADDR_SUM_CTRL, 8'hA0);
        repeat (38) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (50) @(posedge ref_clk);
        ce <= 1'b1;
        repeat (40) @(posedge ref_clk);
        host.wr(ADDR_SUM_CTRL, 8'h00);
        host.rd32(ADDR_TEMP_ELAPSED, v);
        chk(v, 32'h0000_000A);
        host.rd32(ADDR_CHARGE_TIME, v);
        chk(v, 32'h0000_0000);
        host.clr(8'hF8);
        $display("test freeze done");
    endtask : test_freeze

    task automatic test_sched;
        for (int e = 0; e < 3; e++)
        begin
            host.wr(ADDR_CONV_SETUP, 8'hC0 | 8'(e));
            wait_start(100, 1'b1, n);
            wait_start(100, 1'b1, n);
            chk(32'(n), 32'(8 << e));
            chk(32'(convContinuous), 32'h0000_0000);
        end
        @(posedge ref_clk);
        lowPowerHold <= 1'b1;
        wait_start(80, 1'b0, n);
        chk(32'(convStart), 32'h0000_0000);
        @(posedge ref_clk);
        lowPowerHold <= 1'b0;
        host.wr(ADDR_CONV_SETUP, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk(32'(convContinuous), 32'h0000_0001);
        host.wr(ADDR_CONV_SETUP, 8'h00);
        wait_start(80, 1'b0, n);
        chk(32'(convStart), 32'h0000_0000);
        chk(32'(convContinuous), 32'h0000_0000);
        $display("test scheduler done");
    endtask : test_sched

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        test_regs();
        test_temp_sum();
        test_cell2_sum();
        test_elapsed();
        test_freeze();
        test_sched();
        final_report();
    end

    initial
    begin
        #2_000_000;
        miscompares++;
        final_report();
    end
endmodule : testbench
